/* File: rtl/adc_regs_pkg.sv */
// constants and types shared by the converter configuration and digital i/o registers
package adc_regs_pkg;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam int          ADDR_W                 = 5;
	localparam logic [4:0]  ADDR_READBACK_CLOCKDIV = 5'h03;
	localparam logic [4:0]  ADDR_GAIN_CHANNEL      = 5'h04;
	localparam logic [4:0]  ADDR_IO_PIN_STATE      = 5'h05;
	localparam logic [4:0]  ADDR_IO_PIN_DIRECTION  = 5'h06;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CONVERT_FLAG_BIT = 7;
	localparam int GAIN_MSB         = 6;
	localparam int GAIN_LSB         = 4;
	localparam int CHANNEL_MSB      = 3;
	localparam int CHANNEL_LSB      = 0;
	localparam int SINGLE_ENDED_BIT = 3;
	localparam int POLARITY_BIT     = 2;
	localparam int READBACK_MSB     = 3;
	localparam int READBACK_LSB     = 2;
	localparam int CLKDIV_MSB       = 1;
	localparam int CLKDIV_LSB       = 0;
	localparam int PIN_MSB          = 3;
	localparam int PIN_COUNT        = 4;
	localparam int INPUT_COUNT      = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [3:0] RESET_NIBBLE = 4'h0;
	localparam logic [2:0] RESET_DIVCNT = 3'h0;

	// ----------------------------------------
	// field codes
	// ----------------------------------------
	localparam logic [1:0] READBACK_SEPARATE = 2'h0;
	localparam logic [1:0] READBACK_MS_FIRST = 2'h1;
	localparam logic [1:0] READBACK_LS_FIRST = 2'h2;
	localparam logic [1:0] READBACK_MS_ONLY  = 2'h3;
	localparam logic [1:0] CLKDIV_BY1        = 2'h0;
	localparam logic [1:0] CLKDIV_BY2        = 2'h1;
	localparam logic [1:0] CLKDIV_BY4        = 2'h2;
	localparam logic [1:0] CLKDIV_BY8        = 2'h3;

	// ----------------------------------------
	// timing: pin synchroniser depth
	// ----------------------------------------
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------
	// conversion start sequencer
	// ----------------------------------------
	typedef enum logic [2:0] {
		START_IDLE  = 3'b001,
		START_FALL1 = 3'b010,
		START_FALL2 = 3'b100
	} start_state_t;

endpackage

/* File: rtl/pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// raw pin levels
	input  wire logic [WIDTH-1:0] pin_raw,
	// filtered level and edges
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;

	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync needs WIDTH of at least 1");
	end

	// stage1 feeds stage2 only
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
		end else begin
			stage1_reg <= pin_raw;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// a change counts once stages two and three agree
	always_comb begin
		level_next = level_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (stage2_reg[i] == stage3_reg[i]) begin
				level_next[i] = stage3_reg[i];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_reg <= '0;
		end else begin
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
	assign rise  = level_next & ~level_reg;
	assign fall  = ~level_next & level_reg;

endmodule

/* File: rtl/adc_config_and_gpio_regs.sv */
// converter configuration, conversion start and digital i/o register set
//
// Summary of operation
// - The two-bit readback_select field picks separate read, MS byte first, LS byte first or MS byte only.
// - The clock_divide_select codes 0 to 3 divide the conversion clock pin by 1, 2, 4 and 8.
// - Address 4 holds gain_code in bits 6..4, channel_code in bits 3..0 and convert_flag in bit 7.
// - A direct-mode start loads the instruction byte into the gain and channel register.
// - In differential mode polarity_swap_bit swaps the positive and negative pin of the pair.
// - Writing convert_flag as 1 at address 4 starts a conversion on the second later clock fall.
// - Reading convert_flag returns 1 while a conversion is in progress and 0 when idle.
// - Bit 7 at address 5 is the same convert_flag, starting on write and reporting busy on read.
// - gain_code 0 to 7 selects gains 1, 2, 4, 5, 8, 10, 16 and 20.
// - A write never changes the state bit of a pin configured as input.
// - Reads of the pin state bits return the actual pin levels, not the output latch.
// - A pin configured as output is driven with the value written to its state bit.
// - At address 6 a direction bit of 1 makes the pin an output and 0 makes it an input.
// - Bits 6..4 of the pin state register always read as 0.
// - All mapped registers read as eight bits and clear to 0 on reset; the registered decodes reset to gain 1 and the mux to inputs 0 and 1.
`timescale 1ns/1ps

module adc_config_and_gpio_regs #(
	parameter int PIN_COUNT = adc_regs_pkg::PIN_COUNT
) (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	// register port from the serial interface
	input  wire logic [4:0]               reg_addr,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [7:0]               reg_wdata,
	output logic      [7:0]               reg_rdata,
	output logic                          reg_rvalid,
	// direct-mode instruction
	input  wire logic                     direct_load,
	input  wire logic [7:0]               direct_byte,
	// conversion clock
	input  wire logic                     conversion_clock_pin,
	output logic                          divided_converter_clock,
	// converter core
	input  wire logic                     conv_busy,
	output logic                          conv_start,
	// configuration fields
	output logic      [1:0]               readback_select,
	output logic      [1:0]               clock_divide_select,
	output logic      [2:0]               gain_code,
	output logic      [4:0]               gain_factor,
	output logic      [3:0]               channel_code,
	output logic                          polarity_swap_bit,
	output logic                          differential_mode,
	output logic      [7:0]               pos_input_sel,
	output logic      [7:0]               neg_input_sel,
	output logic                          neg_is_common,
	// digital i/o pins
	input  wire logic [PIN_COUNT-1:0]     pin_in,
	output logic      [PIN_COUNT-1:0]     pin_out,
	output logic      [PIN_COUNT-1:0]     pin_oe
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [3:0]                     readback_clockdiv_reg;
	logic [6:0]                     gain_channel_reg;
	logic [PIN_COUNT-1:0]           pin_latch_reg;
	logic [PIN_COUNT-1:0]           pin_direction_reg;
	logic [7:0]                     rdata_reg;
	logic [7:0]                     rdata_next;
	logic                           rvalid_reg;
	logic                           conv_start_reg;
	logic [2:0]                     divcnt_reg;
	logic                           divclk_reg;
	logic                           divclk_next;
	logic [4:0]                     gain_factor_reg;
	logic [4:0]                     gain_factor_next;
	logic [7:0]                     pos_sel_reg;
	logic [7:0]                     neg_sel_reg;
	logic [7:0]                     pos_sel_next;
	logic [7:0]                     neg_sel_next;
	logic                           neg_common_reg;
	logic                           neg_common_next;
	logic                           conversion_clock_pin_level;
	logic                           conversion_clock_pin_fall;
	logic [PIN_COUNT-1:0]           pin_level;
	logic                           wr_ctrl;
	logic                           wr_gain;
	logic                           wr_state;
	logic                           wr_dir;
	logic                           start_request;
	logic                           busy_flag;
	adc_regs_pkg::start_state_t     start_state_reg;
	adc_regs_pkg::start_state_t     start_state_next;

	// register layout is fixed at four pins
	if (PIN_COUNT != adc_regs_pkg::PIN_COUNT) begin : g_bad_pins
		$error("adc_config_and_gpio_regs serves exactly four i/o pins");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	pin_sync #(
		.WIDTH(1)
	) u_conversion_clock_pin_sync (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pin_raw (conversion_clock_pin),
		.level   (conversion_clock_pin_level),
		.rise    (),
		.fall    (conversion_clock_pin_fall)
	);

	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_io_sync (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pin_raw (pin_in),
		.level   (pin_level),
		.rise    (),
		.fall    ()
	);

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	assign wr_ctrl  = reg_wr && (reg_addr == adc_regs_pkg::ADDR_READBACK_CLOCKDIV);
	assign wr_gain  = reg_wr && (reg_addr == adc_regs_pkg::ADDR_GAIN_CHANNEL);
	assign wr_state = reg_wr && (reg_addr == adc_regs_pkg::ADDR_IO_PIN_STATE);
	assign wr_dir   = reg_wr && (reg_addr == adc_regs_pkg::ADDR_IO_PIN_DIRECTION);

	// convert_flag written as 1 at either address, or a direct-mode byte with it set
	assign start_request = ((wr_gain || wr_state)
		&& reg_wdata[adc_regs_pkg::CONVERT_FLAG_BIT])
		|| (direct_load && direct_byte[adc_regs_pkg::CONVERT_FLAG_BIT]);

	// ----------------------------------------
	// readback and clock divide register
	// ----------------------------------------
	// upper four bits are not stored; host keeps them zero
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			readback_clockdiv_reg <= adc_regs_pkg::RESET_NIBBLE;
		end else if (wr_ctrl) begin
			readback_clockdiv_reg <= reg_wdata[adc_regs_pkg::READBACK_MSB:0];
		end
	end

	assign readback_select     = readback_clockdiv_reg[adc_regs_pkg::READBACK_MSB:
		adc_regs_pkg::READBACK_LSB];
	assign clock_divide_select = readback_clockdiv_reg[adc_regs_pkg::CLKDIV_MSB:
		adc_regs_pkg::CLKDIV_LSB];

	// ----------------------------------------
	// gain and channel register
	// ----------------------------------------
	// direct mode wins over a register write in the same cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gain_channel_reg <= adc_regs_pkg::RESET_BYTE[6:0];
		end else if (direct_load) begin
			gain_channel_reg <= direct_byte[adc_regs_pkg::GAIN_MSB:0];
		end else if (wr_gain) begin
			gain_channel_reg <= reg_wdata[adc_regs_pkg::GAIN_MSB:0];
		end
	end

	assign gain_code         = gain_channel_reg[adc_regs_pkg::GAIN_MSB:adc_regs_pkg::GAIN_LSB];
	assign channel_code      = gain_channel_reg[adc_regs_pkg::CHANNEL_MSB:
		adc_regs_pkg::CHANNEL_LSB];
	assign polarity_swap_bit = channel_code[adc_regs_pkg::POLARITY_BIT];
	assign differential_mode = !channel_code[adc_regs_pkg::SINGLE_ENDED_BIT];

	// ----------------------------------------
	// gain decode
	// ----------------------------------------
	always_comb begin
		unique case (gain_code)
			3'h0: gain_factor_next = 5'h01;
			3'h1: gain_factor_next = 5'h02;
			3'h2: gain_factor_next = 5'h04;
			3'h3: gain_factor_next = 5'h05;
			3'h4: gain_factor_next = 5'h08;
			3'h5: gain_factor_next = 5'h0a;
			3'h6: gain_factor_next = 5'h10;
			3'h7: gain_factor_next = 5'h14;
		endcase
	end

	// ----------------------------------------
	// input multiplexer decode
	// ----------------------------------------
	// differential pairs are inputs 2k and 2k+1; single-ended uses the common input as minus
	always_comb begin
		pos_sel_next    = 8'h00;
		neg_sel_next    = 8'h00;
		neg_common_next = 1'b0;
		if (differential_mode) begin
			if (polarity_swap_bit) begin
				pos_sel_next[{channel_code[1:0], 1'b1}] = 1'b1;
				neg_sel_next[{channel_code[1:0], 1'b0}] = 1'b1;
			end else begin
				pos_sel_next[{channel_code[1:0], 1'b0}] = 1'b1;
				neg_sel_next[{channel_code[1:0], 1'b1}] = 1'b1;
			end
		end else begin
			pos_sel_next[channel_code[2:0]] = 1'b1;
			neg_common_next                 = 1'b1;
		end
	end

	// decodes are registered so the analog switches see clean levels
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gain_factor_reg <= 5'h01;
			pos_sel_reg     <= 8'h01;
			neg_sel_reg     <= 8'h02;
			neg_common_reg  <= 1'b0;
		end else begin
			gain_factor_reg <= gain_factor_next;
			pos_sel_reg     <= pos_sel_next;
			neg_sel_reg     <= neg_sel_next;
			neg_common_reg  <= neg_common_next;
		end
	end

	assign gain_factor   = gain_factor_reg;
	assign pos_input_sel = pos_sel_reg;
	assign neg_input_sel = neg_sel_reg;
	assign neg_is_common = neg_common_reg;

	// ----------------------------------------
	// conversion clock divider
	// ----------------------------------------
	// counts falls of the synchronised pin; fine for pin rates well under ref_clk/6
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			divcnt_reg <= adc_regs_pkg::RESET_DIVCNT;
		end else if (conversion_clock_pin_fall) begin
			divcnt_reg <= divcnt_reg + 3'h1;
		end
	end

	always_comb begin
		unique case (clock_divide_select)
			adc_regs_pkg::CLKDIV_BY1: divclk_next = conversion_clock_pin_level;
			adc_regs_pkg::CLKDIV_BY2: divclk_next = divcnt_reg[0];
			adc_regs_pkg::CLKDIV_BY4: divclk_next = divcnt_reg[1];
			adc_regs_pkg::CLKDIV_BY8: divclk_next = divcnt_reg[2];
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			divclk_reg <= 1'b0;
		end else begin
			divclk_reg <= divclk_next;
		end
	end

	assign divided_converter_clock = divclk_reg;

	// ----------------------------------------
	// conversion start sequencer
	// ----------------------------------------
	// a fall in the latching cycle itself is not counted; a request while pending is absorbed
	always_comb begin
		start_state_next = start_state_reg;
		unique case (start_state_reg)
			adc_regs_pkg::START_IDLE: begin
				if (start_request) begin
					start_state_next = adc_regs_pkg::START_FALL1;
				end
			end
			adc_regs_pkg::START_FALL1: begin
				if (conversion_clock_pin_fall) begin
					start_state_next = adc_regs_pkg::START_FALL2;
				end
			end
			adc_regs_pkg::START_FALL2: begin
				if (conversion_clock_pin_fall) begin
					start_state_next = adc_regs_pkg::START_IDLE;
				end
			end
			default: begin
				start_state_next = adc_regs_pkg::START_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_state_reg <= adc_regs_pkg::START_IDLE;
		end else begin
			start_state_reg <= start_state_next;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_start_reg <= 1'b0;
		end else begin
			conv_start_reg <= (start_state_reg == adc_regs_pkg::START_FALL2)
				&& conversion_clock_pin_fall;
		end
	end

	assign conv_start = conv_start_reg;

	// pending start counts as busy so a read right after the write sees it
	assign busy_flag = conv_busy || (start_state_reg != adc_regs_pkg::START_IDLE)
		|| conv_start_reg;

	// ----------------------------------------
	// digital i/o latch and direction
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_direction_reg <= adc_regs_pkg::RESET_NIBBLE;
		end else if (wr_dir) begin
			pin_direction_reg <= reg_wdata[adc_regs_pkg::PIN_MSB:0];
		end
	end

	// only output pins take the written value
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_latch_reg <= adc_regs_pkg::RESET_NIBBLE;
		end else if (wr_state) begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				if (pin_direction_reg[i]) begin
					pin_latch_reg[i] <= reg_wdata[i];
				end
			end
		end
	end

	assign pin_out = pin_latch_reg;
	assign pin_oe  = pin_direction_reg;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// unmapped addresses read zero; the block owns no other addresses
	always_comb begin
		rdata_next = adc_regs_pkg::RESET_BYTE;
		unique case (reg_addr)
			adc_regs_pkg::ADDR_READBACK_CLOCKDIV: begin
				rdata_next = {4'h0, readback_clockdiv_reg};
			end
			adc_regs_pkg::ADDR_GAIN_CHANNEL: begin
				rdata_next = {busy_flag, gain_channel_reg};
			end
			adc_regs_pkg::ADDR_IO_PIN_STATE: begin
				rdata_next = {busy_flag, 3'h0, pin_level};
			end
			adc_regs_pkg::ADDR_IO_PIN_DIRECTION: begin
				rdata_next = {4'h0, pin_direction_reg};
			end
			default: begin
				rdata_next = adc_regs_pkg::RESET_BYTE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg  <= adc_regs_pkg::RESET_BYTE;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_rd;
			if (reg_rd) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign reg_rdata  = rdata_reg;
	assign reg_rvalid = rvalid_reg;

endmodule

/* File: bench/adc_regs_checker.sv */
// assertions on the ports of the configuration and digital i/o register set
`timescale 1ns/1ps

module adc_regs_checker #(
	parameter int PIN_COUNT = 4
) (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 sys_rst,
	// register port and starts
	input wire logic [4:0]           reg_addr,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [7:0]           reg_wdata,
	input wire logic [7:0]           reg_rdata,
	input wire logic                 direct_load,
	input wire logic [7:0]           direct_byte,
	input wire logic                 conv_busy,
	input wire logic                 conv_start,
	// fields and pins
	input wire logic [2:0]           gain_code,
	input wire logic [4:0]           gain_factor,
	input wire logic [3:0]           channel_code,
	input wire logic                 polarity_swap_bit,
	input wire logic                 differential_mode,
	input wire logic [PIN_COUNT-1:0] pin_out,
	input wire logic [PIN_COUNT-1:0] pin_oe
);
	localparam logic [4:0] GAINS [8] = '{5'h01, 5'h02, 5'h04, 5'h05,
		5'h08, 5'h0a, 5'h10, 5'h14};
	logic start_req;
	logic wr4;
	logic rd45;
	assign wr4 = reg_wr && reg_addr == 5'h04 && !direct_load;
	assign rd45 = reg_rd && (reg_addr == 5'h04 || reg_addr == 5'h05);
	assign start_req = (reg_wr && reg_wdata[7] && (reg_addr == 5'h04 || reg_addr == 5'h05))
		|| (direct_load && direct_byte[7]);

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// -------------------------
	// conversion start and busy
	// -------------------------
	// bound assumes the bench's conversion clock of 80 ns
	a_start_bounded: assert property (start_req |-> ##[2:60] conv_start)
		else $error("no conversion start after request");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	a_busy_read: assert property (rd45 && conv_busy |=> reg_rdata[7])
		else $error("busy flag low while converting");
	a_pending_busy: assert property (rd45 && $past(start_req, 2) |=> reg_rdata[7])
		else $error("busy flag low while start pending");
	// -------------------------
	// fields and pins
	// -------------------------
	a_gain_read: assert property (rd45 && reg_addr == 5'h04 && !reg_wr && !direct_load
		|=> reg_rdata[6:0] == {gain_code, channel_code})
		else $error("gain and channel read mismatch");
	a_unused_zero: assert property (reg_rd && reg_addr == 5'h05 |=> reg_rdata[6:4] == 3'h0)
		else $error("unused pin state bits not zero");
	a_ctrl_upper: assert property (reg_rd && reg_addr == 5'h03 |=> reg_rdata[7:4] == 4'h0)
		else $error("reserved control bits not zero");
	a_gain_write: assert property (wr4 |=> {gain_code, channel_code} == $past(reg_wdata[6:0]))
		else $error("gain and channel not written");
	a_direct_load: assert property (direct_load
		|=> {gain_code, channel_code} == $past(direct_byte[6:0]))
		else $error("direct byte not loaded");
	a_gain_decode: assert property (gain_factor == GAINS[$past(gain_code)])
		else $error("gain factor decode wrong");
	a_mux_fields: assert property (wr4 |=> polarity_swap_bit == $past(reg_wdata[2])
		&& differential_mode == !$past(reg_wdata[3]))
		else $error("polarity or mode field wrong");
	a_dir_write: assert property (reg_wr && reg_addr == 5'h06
		|=> pin_oe == $past(reg_wdata[3:0]))
		else $error("direction not written");
	a_latch_write: assert property (reg_wr && reg_addr == 5'h05 |=> pin_out ==
		(($past(reg_wdata[3:0]) & $past(pin_oe)) | ($past(pin_out) & ~$past(pin_oe))))
		else $error("output latch update wrong");

	c_start: cover property (conv_start);
	c_direct: cover property (direct_load && direct_byte[7]);
	c_pin_read: cover property (reg_rd && reg_addr == 5'h05);
endmodule

bind adc_config_and_gpio_regs adc_regs_checker #(.PIN_COUNT(PIN_COUNT)) u_checker (
	.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.direct_load, .direct_byte, .conv_busy, .conv_start, .gain_code, .gain_factor,
	.channel_code, .polarity_swap_bit, .differential_mode, .pin_out, .pin_oe
);

/* File: bench/host_model.sv */
// host model: drives register accesses and direct-mode starts
`timescale 1ns/1ps

module host_model (
	// clock
	input  wire logic       ref_clk,
	// register port
	output logic      [4:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	// direct-mode start
	output logic            direct_load,
	output logic      [7:0] direct_byte
);
	initial begin
		reg_addr = 5'h1f;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h5a;
		direct_load = 1'b0;
		direct_byte = 8'ha5;
	end

	// released data is inverted so stale values are never mistaken for live ones
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = (a == 5'h03) ? {4'h0, d[3:0]} : d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask

	task automatic direct(input logic [7:0] b);
		@(negedge ref_clk);
		direct_byte = b;
		direct_load = 1'b1;
		@(negedge ref_clk);
		direct_load = 1'b0;
		direct_byte = ~b;
	endtask
endmodule

/* File: bench/adc_config_and_gpio_regs_test.sv */
// self-checking testbench for the configuration and digital i/o register set
`timescale 1ns/1ps

module adc_config_and_gpio_regs_test;
	localparam logic [7:0] GAINS [8] = '{8'h01, 8'h02, 8'h04, 8'h05,
		8'h08, 8'h0a, 8'h10, 8'h14};
	logic       ref_clk;
	logic       sys_rst;
	logic [4:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic       direct_load;
	logic [7:0] direct_byte;
	logic       conversion_clock_pin;
	logic       divided_converter_clock;
	logic       conv_busy;
	logic       conv_start;
	logic [1:0] readback_select;
	logic [1:0] clock_divide_select;
	logic [4:0] gain_factor;
	logic [7:0] pos_input_sel;
	logic [7:0] neg_input_sel;
	logic       neg_is_common;
	logic [3:0] pin_in;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic [3:0] ext_level;
	logic [3:0] fault;
	logic [7:0] d;
	logic [7:0] e;
	logic       div_prev;
	int         fails;
	int         tests_run;
	int         falls;
	int         rises;
	int         p;
	int         n;

	// a faulted output pin is pulled low whatever the latch says
	assign pin_in = (pin_oe & pin_out & ~fault) | (~pin_oe & ext_level);

	host_model u_host (.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_rvalid, .direct_load, .direct_byte);

	adc_config_and_gpio_regs u_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .reg_rvalid, .direct_load, .direct_byte,
		.conversion_clock_pin, .divided_converter_clock, .conv_busy, .conv_start,
		.readback_select, .clock_divide_select, .gain_code(), .gain_factor,
		.channel_code(), .polarity_swap_bit(), .differential_mode(), .pos_input_sel,
		.neg_input_sel, .neg_is_common, .pin_in, .pin_out, .pin_oe);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// offset keeps conversion clock edges away from the bench's drive edge
	initial begin
		conversion_clock_pin = 1'b0;
		#3;
		forever #40 conversion_clock_pin = ~conversion_clock_pin;
	end

	always @(negedge conversion_clock_pin) falls++;

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		fails++;
		end_sim();
	end

	initial begin
		sys_rst = 1'b1;
		conv_busy = 1'b0;
		ext_level = 4'h0;
		fault = 4'h0;
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		// -------------------------
		// reset values and divider
		// -------------------------
		for (int a = 3; a < 7; a++) begin
			u_host.rd(5'(a), d);
			check(d, 8'h00);
		end
		u_host.rd(5'h1f, d);
		check(d, 8'h00);
		for (int i = 0; i < 4; i++) begin
			u_host.wr(5'h03, {4'h0, 2'(i), 2'(i)});
			@(negedge ref_clk);
			check(8'({readback_select, clock_divide_select}), 8'(i * 5));
			u_host.rd(5'h03, d);
			check(d, 8'(i * 5));
			repeat (40) @(negedge ref_clk);
			rises = 0;
			div_prev = divided_converter_clock;
			repeat (512) begin
				@(negedge ref_clk);
				rises += int'(divided_converter_clock && !div_prev);
				div_prev = divided_converter_clock;
			end
			check(8'((rises << i) >= 56 && (rises << i) <= 72), 8'h01);
		end
		// -------------------------
		// gain and channel codes
		// -------------------------
		for (int c = 0; c < 16; c++) begin
			e = {1'b0, 3'(c), 4'(c)};
			u_host.wr(5'h04, e);
			repeat (2) @(negedge ref_clk);
			check(8'(gain_factor), GAINS[c % 8]);
			p = c[3] ? c % 8 : 2 * (c % 4) + c[2];
			check(pos_input_sel, 8'h01 << p);
			check(8'(neg_is_common), 8'(c[3]));
			if (!c[3]) check(neg_input_sel, 8'h01 << (p ^ 1));
			u_host.rd(5'h04, d);
			check(d, e);
		end
		// -------------------------
		// conversion starts
		// -------------------------
		for (int k = 0; k < 3; k++) begin
			@(posedge conversion_clock_pin);
			falls = 0;
			if (k == 2) u_host.direct(8'h9a);
			else u_host.wr(k == 0 ? 5'h04 : 5'h05, 8'h80);
			u_host.rd(5'h04, d);
			check(8'(d[7]), 8'h01);
			for (n = 0; n < 80 && conv_start !== 1'b1; n++) @(negedge ref_clk);
			check(8'(falls), 8'h02);
			conv_busy = 1'b1;
			u_host.rd(5'h05, d);
			check(8'(d[7]), 8'h01);
			conv_busy = 1'b0;
			u_host.rd(5'h04, d);
			check(d, k == 2 ? 8'h1a : 8'h00);
		end
		// -------------------------
		// digital i/o pins
		// -------------------------
		ext_level = 4'h4;
		u_host.wr(5'h06, 8'h03);
		check(8'(pin_oe), 8'h03);
		u_host.wr(5'h05, 8'h0f);
		check(8'(pin_out), 8'h03);
		repeat (6) @(negedge ref_clk);
		u_host.rd(5'h05, d);
		check(d, 8'h07);
		fault = 4'h1;
		repeat (6) @(negedge ref_clk);
		u_host.rd(5'h05, d);
		check(d, 8'h06);
		fault = 4'h0;
		u_host.wr(5'h06, 8'h0c);
		u_host.wr(5'h05, 8'h0a);
		check(8'(pin_out), 8'h0b);
		repeat (6) @(negedge ref_clk);
		u_host.rd(5'h05, d);
		check(d, 8'h08);
		end_sim();
	end
endmodule
